// ==== inc/link_mon_pkg.sv ====
// shared constants for the serializer link status monitor
package link_mon_pkg;
  localparam logic [7:0] OFS_PIN_DATA   = 8'h0d;
  localparam logic [7:0] OFS_PIN_DIR    = 8'h0e;
  localparam logic [7:0] OFS_SNS_SEL    = 8'h17;
  localparam logic [7:0] OFS_SNS_GAIN   = 8'h18;
  localparam logic [7:0] OFS_SNS_LIM    = 8'h1a;
  localparam logic [7:0] OFS_ALM_EN     = 8'h1d;
  localparam logic [7:0] OFS_ALM_FWD    = 8'h1e;
  localparam logic [7:0] OFS_DIAG_CLR   = 8'h49;
  localparam logic [7:0] OFS_LINK_STS   = 8'h52;
  localparam logic [7:0] OFS_PIN_STS    = 8'h53;
  localparam logic [7:0] OFS_ST_CNT     = 8'h54;
  localparam logic [7:0] OFS_CRC_CNT_A  = 8'h55;
  localparam logic [7:0] OFS_CRC_CNT_B  = 8'h56;
  localparam logic [7:0] OFS_SNS_STS    = 8'h57;
  localparam logic [7:0] OFS_BC_RATE    = 8'h59;
  // field positions
  localparam int BIT_CRC_FLAG    = 1;
  localparam int BIT_PLL_LOCK    = 2;
  localparam int BIT_ST_FLAG     = 3;
  localparam int BIT_REMOTE_LOCK = 6;
  localparam int BIT_CRC_CLR     = 3;
  localparam int BIT_ST_CLR      = 5;
  localparam int BIT_VOLT_LOW    = 2;
  localparam int BIT_VOLT_HIGH   = 3;
  localparam int BIT_TEMP_LOW    = 0;
  localparam int BIT_TEMP_HIGH   = 1;
  localparam int BIT_ALM_VOLT    = 0;
  localparam int BIT_ALM_TEMP    = 1;
  localparam int BIT_VSEL_PIN1   = 1;
  // back-channel frame layout
  localparam int FRAME_BITS      = 30;
  localparam int FR_SLOT_LSB     = 26;
  localparam int FR_ST_EN        = 25;
  localparam int FR_RLOCK        = 24;
  localparam int FR_CMD_LSB      = 8;
  localparam int CRC_BITS        = 8;
  localparam logic [7:0] CRC_POLY = 8'h07;
  // link-clock edges per bit at the two rates
  localparam logic [3:0] EDGES_FAST = 4'h2;
  localparam logic [3:0] EDGES_SLOW = 4'ha;
  // reset values and the strap settle count
  localparam logic [7:0] RST_PIN_DIR  = 8'h0f;
  localparam logic [7:0] RST_SNS_LIM  = 8'h62;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_PRBS     = 8'h7f;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  typedef enum logic [6:0] {
    I2C_IDLE = 7'h01,
    I2C_ADDR = 7'h02,
    I2C_AACK = 7'h04,
    I2C_WDAT = 7'h08,
    I2C_WACK = 7'h10,
    I2C_RDAT = 7'h20,
    I2C_RACK = 7'h40
  } i2c_state_type;
endpackage

// ==== core/link_status_monitor.sv ====
// back-channel receiver, diagnostics, sensor alarms and general pins
`timescale 1ns/1ps
`default_nettype none
module link_status_monitor #(
  parameter logic [6:0] DEV_ADDR = 7'h18, // arbitrary bus address
  parameter int         PINS     = 4
) (
  input  wire logic             core_clk_i,     // 25 MHz core clock
  input  wire logic             rst_n_i,        // async reset, active low
  input  wire logic             scl_i,          // host bus clock pin
  input  wire logic             sda_i,          // host bus data pin
  output logic                  sda_o,          // data drive level
  output logic                  sda_oe_o,       // data pulled low
  input  wire logic             bc_clk_i,       // back-channel line clock
  input  wire logic             bc_data_i,      // back-channel serial data
  input  wire logic             bc_sync_i,      // high with first frame bit
  input  wire logic             mode_strap_i,   // mode pin, high = fast back-channel rate
  input  wire logic             tx_pll_locked_i,// forward pll lock
  input  wire logic [2:0]       volt_code_i,    // voltage converter code
  input  wire logic [2:0]       temp_code_i,    // temperature converter code
  input  wire logic [PINS-1:0]  gpio_i,         // general pin levels
  output logic      [PINS-1:0]  gpio_o,         // general pin drive
  output logic      [PINS-1:0]  gpio_oe_o,      // general pin enable
  output logic                  volt_sel_o,     // sense pin select
  output logic                  volt_en_o,      // voltage sensor enable
  output logic      [7:0]       sns_gain_o,     // sensor gain setting
  output logic                  alarm_fwd_o,    // alarm to remote end
  output logic      [15:0]      cmd_data_o,     // control command word
  output logic                  cmd_valid_o,    // one-cycle command strobe
  output logic                  fwd_prbs_o,     // self-test stream bit
  output logic                  fwd_selftest_o  // self-test active
);
  // two-flop synchronisers for all pins except the converter codes
  localparam int NSYNC = 7 + PINS;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {gpio_i, tx_pll_locked_i, mode_strap_i, bc_sync_i,
               bc_data_i, bc_clk_i, sda_i, scl_i};
      s2_q <= s1_q;
    end
  end
  logic scl_s, sda_s, bck_s, bcd_s, bcs_s, strap_s, pll_s;
  logic [PINS-1:0] pin_s;
  assign {pin_s, pll_s, strap_s, bcs_s, bcd_s, bck_s, sda_s, scl_s} = s2_q;

  // register storage
  logic [7:0] pin_data_q, pin_dir_q, sns_sel_q, sns_gain_q, sns_lim_q;
  logic [7:0] alm_en_q, alm_fwd_q, diag_q;
  logic       rate_fast_q;
  logic       wr_stb;
  logic [7:0] wr_addr, wr_data;
  logic       crc_clr, st_clr;
  // single pulse per write of 1, counters never held
  assign crc_clr = wr_stb && wr_addr == link_mon_pkg::OFS_DIAG_CLR
                   && wr_data[link_mon_pkg::BIT_CRC_CLR];
  assign st_clr  = wr_stb && wr_addr == link_mon_pkg::OFS_DIAG_CLR
                   && wr_data[link_mon_pkg::BIT_ST_CLR];

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_data_q <= link_mon_pkg::RST_ZERO;
      pin_dir_q  <= link_mon_pkg::RST_PIN_DIR;
      sns_sel_q  <= link_mon_pkg::RST_ZERO;
      sns_gain_q <= link_mon_pkg::RST_ZERO;
      sns_lim_q  <= link_mon_pkg::RST_SNS_LIM;
      alm_en_q   <= link_mon_pkg::RST_ZERO;
      alm_fwd_q  <= link_mon_pkg::RST_ZERO;
      diag_q     <= link_mon_pkg::RST_ZERO;
    end else if (wr_stb) begin
      case (wr_addr)
        link_mon_pkg::OFS_PIN_DATA: pin_data_q <= wr_data;
        link_mon_pkg::OFS_PIN_DIR:  pin_dir_q  <= wr_data;
        link_mon_pkg::OFS_SNS_SEL:  sns_sel_q  <= wr_data;
        link_mon_pkg::OFS_SNS_GAIN: sns_gain_q <= wr_data;
        link_mon_pkg::OFS_SNS_LIM:  sns_lim_q  <= wr_data;
        link_mon_pkg::OFS_ALM_EN:   alm_en_q   <= wr_data;
        link_mon_pkg::OFS_ALM_FWD:  alm_fwd_q  <= wr_data;
        // clear bits are not stored, they always read zero
        link_mon_pkg::OFS_DIAG_CLR: diag_q <= wr_data & 8'hd7;
        default: ;
      endcase
    end
  end

  // rate default caught from the strap once it has settled
  logic [1:0] settle_q;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      settle_q    <= 2'h0;
      rate_fast_q <= 1'b0;
    end else if (settle_q != link_mon_pkg::STRAP_SETTLE) begin
      settle_q    <= settle_q + 2'h1;
      rate_fast_q <= strap_s;
    end else if (wr_stb && wr_addr == link_mon_pkg::OFS_BC_RATE) begin
      rate_fast_q <= wr_data[0];
    end
  end

  // back-channel bit recovery on sampled line clock
  logic       bck_d1_q;
  logic [3:0] edge_cnt_q;
  logic       bit_stb;
  logic [3:0] edges_per_bit;
  assign edges_per_bit = rate_fast_q ? link_mon_pkg::EDGES_FAST : link_mon_pkg::EDGES_SLOW;
  // one bit per two clock edges at full rate: bit rate is half
  assign bit_stb = bck_s && !bck_d1_q && edge_cnt_q == edges_per_bit - 4'h1;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bck_d1_q   <= 1'b0;
      edge_cnt_q <= 4'h0;
    end else begin
      bck_d1_q <= bck_s;
      if (bck_s && !bck_d1_q) begin
        // sync marker realigns the divider to the frame start
        if (bit_stb || bcs_s) edge_cnt_q <= 4'h0;
        else edge_cnt_q <= edge_cnt_q + 4'h1;
      end
    end
  end

  logic [link_mon_pkg::FRAME_BITS-1:0] frame_sh_q;
  logic [4:0] bit_idx_q;
  logic       frame_done_q;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_sh_q   <= '0;
      bit_idx_q    <= 5'h0;
      frame_done_q <= 1'b0;
    end else begin
      frame_done_q <= 1'b0;
      if (bit_stb) begin
        frame_sh_q <= {frame_sh_q[link_mon_pkg::FRAME_BITS-2:0], bcd_s};
        if (bcs_s) begin
          bit_idx_q <= 5'h1;
        end else if (bit_idx_q == 5'(link_mon_pkg::FRAME_BITS - 1)) begin
          bit_idx_q    <= 5'h0;
          frame_done_q <= 1'b1;
        end else begin
          bit_idx_q <= bit_idx_q + 5'h1;
        end
      end
    end
  end

  // crc over the frame payload, msb first
  localparam int PAYLOAD = link_mon_pkg::FRAME_BITS - link_mon_pkg::CRC_BITS;
  function automatic logic [7:0] crc8(input logic [PAYLOAD-1:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = PAYLOAD - 1; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ((c << 1) ^ link_mon_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
  logic crc_bad;
  assign crc_bad = frame_done_q && crc8(frame_sh_q[link_mon_pkg::FRAME_BITS-1:link_mon_pkg::CRC_BITS])
                   != frame_sh_q[link_mon_pkg::CRC_BITS-1:0];

  // frame contents, taken only from good frames
  logic [PINS-1:0] slot_q;
  logic st_active_q, rlock_q;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot_q      <= '0;
      st_active_q <= 1'b0;
      rlock_q     <= 1'b0;
      cmd_data_o  <= 16'h0000;
      cmd_valid_o <= 1'b0;
    end else begin
      cmd_valid_o <= 1'b0;
      if (frame_done_q && !crc_bad) begin
        slot_q      <= frame_sh_q[link_mon_pkg::FR_SLOT_LSB +: PINS];
        st_active_q <= frame_sh_q[link_mon_pkg::FR_ST_EN];
        rlock_q     <= frame_sh_q[link_mon_pkg::FR_RLOCK];
        cmd_data_o  <= frame_sh_q[link_mon_pkg::FR_CMD_LSB +: 16];
        cmd_valid_o <= 1'b1;
      end
    end
  end

  // error counters and flags; an error in the clear cycle survives
  logic [15:0] crc_cnt_q;
  logic [7:0]  st_cnt_q;
  logic        crc_flag_q, st_flag_q;
  logic        st_err;
  assign st_err = crc_bad && st_active_q;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crc_cnt_q  <= 16'h0000;
      crc_flag_q <= 1'b0;
    end else if (crc_bad) begin
      crc_flag_q <= 1'b1;
      crc_cnt_q  <= crc_clr ? 16'h0001 :
                    (&crc_cnt_q ? crc_cnt_q : crc_cnt_q + 16'h0001);
    end else if (crc_clr) begin
      crc_flag_q <= 1'b0;
      crc_cnt_q  <= 16'h0000;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_cnt_q  <= 8'h00;
      st_flag_q <= 1'b0;
    end else if (st_err) begin
      st_flag_q <= 1'b1;
      st_cnt_q  <= st_clr ? 8'h01 : (&st_cnt_q ? st_cnt_q : st_cnt_q + 8'h01);
    end else if (st_clr) begin
      st_flag_q <= 1'b0;
      st_cnt_q  <= 8'h00;
    end
  end

  // self-test forward stream, prbs7 at core rate
  logic [6:0] prbs_q;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prbs_q         <= link_mon_pkg::RST_PRBS[6:0];
      fwd_prbs_o     <= 1'b0;
      fwd_selftest_o <= 1'b0;
    end else begin
      fwd_selftest_o <= st_active_q;
      if (st_active_q) begin
        prbs_q     <= {prbs_q[5:0], prbs_q[6] ^ prbs_q[5]};
        fwd_prbs_o <= prbs_q[6];
      end else begin
        fwd_prbs_o <= 1'b0;
      end
    end
  end

  // sensor limits: upper in [6:4], lower in [2:0]
  logic v_low, v_high, t_low, t_high;
  logic [7:0] sns_sts_q;
  assign v_low  = volt_code_i < sns_lim_q[2:0];
  assign v_high = volt_code_i > sns_lim_q[6:4];
  assign t_low  = temp_code_i < sns_lim_q[2:0];
  assign t_high = temp_code_i > sns_lim_q[6:4];
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sns_sts_q   <= 8'h00;
      alarm_fwd_o <= 1'b0;
      volt_sel_o  <= 1'b0;
      volt_en_o   <= 1'b0;
      sns_gain_o  <= 8'h00;
    end else begin
      sns_sts_q <= 8'h00;
      sns_sts_q[link_mon_pkg::BIT_VOLT_LOW]  <= v_low;
      sns_sts_q[link_mon_pkg::BIT_VOLT_HIGH] <= v_high;
      sns_sts_q[link_mon_pkg::BIT_TEMP_LOW]  <= t_low;
      sns_sts_q[link_mon_pkg::BIT_TEMP_HIGH] <= t_high;
      // local enable gates the alarm, forward enable gates sending it
      alarm_fwd_o <= (alm_en_q[link_mon_pkg::BIT_ALM_VOLT] && alm_fwd_q[link_mon_pkg::BIT_ALM_VOLT]
                      && (v_low || v_high))
                  || (alm_en_q[link_mon_pkg::BIT_ALM_TEMP] && alm_fwd_q[link_mon_pkg::BIT_ALM_TEMP]
                      && (t_low || t_high));
      // one select bit: only pin 0 or pin 1 can be sensed
      volt_sel_o <= sns_sel_q[link_mon_pkg::BIT_VSEL_PIN1];
      volt_en_o  <= sns_sel_q[0];
      sns_gain_o <= sns_gain_q;
    end
  end

  // general pins: dir [7:4] output enable, vetoed by dir [3:0]; data [7:4] pick remote slot
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          gpio_o[g]    <= 1'b0;
          gpio_oe_o[g] <= 1'b0;
        end else begin
          gpio_oe_o[g] <= pin_dir_q[4+g] && !pin_dir_q[g];
          // remote slot gives about one frame of skew
          gpio_o[g] <= pin_data_q[4+g] ? slot_q[g] : pin_data_q[g];
        end
      end
    end
  endgenerate

  logic [7:0] ptr_q;   // host register pointer, also the read mux select
  logic [7:0] rd_data;
  always_comb begin
    rd_data = 8'h00;
    case (ptr_q)
      link_mon_pkg::OFS_PIN_DATA:  rd_data = pin_data_q;
      link_mon_pkg::OFS_PIN_DIR:   rd_data = pin_dir_q;
      link_mon_pkg::OFS_SNS_SEL:   rd_data = sns_sel_q;
      link_mon_pkg::OFS_SNS_GAIN:  rd_data = sns_gain_q;
      link_mon_pkg::OFS_SNS_LIM:   rd_data = sns_lim_q;
      link_mon_pkg::OFS_ALM_EN:    rd_data = alm_en_q;
      link_mon_pkg::OFS_ALM_FWD:   rd_data = alm_fwd_q;
      link_mon_pkg::OFS_DIAG_CLR:  rd_data = diag_q;
      link_mon_pkg::OFS_LINK_STS: begin
        rd_data[link_mon_pkg::BIT_CRC_FLAG]    = crc_flag_q;
        rd_data[link_mon_pkg::BIT_PLL_LOCK]    = pll_s;
        rd_data[link_mon_pkg::BIT_ST_FLAG]     = st_flag_q;
        rd_data[link_mon_pkg::BIT_REMOTE_LOCK] = rlock_q;
      end
      link_mon_pkg::OFS_PIN_STS:   rd_data = 8'(pin_s);
      link_mon_pkg::OFS_ST_CNT:    rd_data = st_cnt_q;
      link_mon_pkg::OFS_CRC_CNT_A: rd_data = crc_cnt_q[7:0];
      link_mon_pkg::OFS_CRC_CNT_B: rd_data = crc_cnt_q[15:8];
      link_mon_pkg::OFS_SNS_STS:   rd_data = sns_sts_q;
      link_mon_pkg::OFS_BC_RATE:   rd_data = {7'h00, rate_fast_q};
      default: rd_data = 8'h00;
    endcase
  end

  // host bus slave, sampled pins; first written byte is the pointer
  link_mon_pkg::i2c_state_type st_q;
  logic       scl_d1_q, sda_d1_q, first_q;
  logic [3:0] bcnt_q;
  logic [7:0] sh_q;
  logic       rise, fall, start, stop;
  assign rise  = scl_s && !scl_d1_q;
  assign fall  = !scl_s && scl_d1_q;
  assign start = scl_s && scl_d1_q && sda_d1_q && !sda_s;
  assign stop  = scl_s && scl_d1_q && !sda_d1_q && sda_s;
  assign wr_stb  = fall && st_q == link_mon_pkg::I2C_WDAT && bcnt_q == 4'h8 && !first_q;
  assign wr_addr = ptr_q;
  assign wr_data = sh_q;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q     <= link_mon_pkg::I2C_IDLE;
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
      first_q  <= 1'b0;
      bcnt_q   <= 4'h0;
      sh_q     <= 8'h00;
      ptr_q    <= 8'h00;
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      scl_d1_q <= scl_s;
      sda_d1_q <= sda_s;
      if (start) begin
        st_q     <= link_mon_pkg::I2C_ADDR;
        bcnt_q   <= 4'h0;
        first_q  <= 1'b1;
        sda_oe_o <= 1'b0;
      end else if (stop) begin
        st_q     <= link_mon_pkg::I2C_IDLE;
        sda_oe_o <= 1'b0;
      end else if (rise) begin
        bcnt_q <= bcnt_q + 4'h1;
        if (st_q == link_mon_pkg::I2C_ADDR || st_q == link_mon_pkg::I2C_WDAT)
          sh_q <= {sh_q[6:0], sda_s};
        if (st_q == link_mon_pkg::I2C_RACK && sda_s)
          st_q <= link_mon_pkg::I2C_IDLE;
      end else if (fall) begin
        case (st_q)
          link_mon_pkg::I2C_ADDR: if (bcnt_q == 4'h8) begin
            if (sh_q[7:1] == DEV_ADDR) begin
              st_q     <= link_mon_pkg::I2C_AACK;
              sda_oe_o <= 1'b1;
              first_q  <= !sh_q[0];
            end else begin
              st_q <= link_mon_pkg::I2C_IDLE;
            end
          end
          link_mon_pkg::I2C_AACK, link_mon_pkg::I2C_RACK: begin
            bcnt_q <= 4'h0;
            if (first_q || st_q == link_mon_pkg::I2C_AACK && !sh_q[0]) begin
              st_q     <= link_mon_pkg::I2C_WDAT;
              sda_oe_o <= 1'b0;
            end else begin
              st_q     <= link_mon_pkg::I2C_RDAT;
              sh_q     <= rd_data;
              sda_oe_o <= !rd_data[7];
            end
          end
          link_mon_pkg::I2C_WDAT: if (bcnt_q == 4'h8) begin
            st_q     <= link_mon_pkg::I2C_WACK;
            sda_oe_o <= 1'b1;
            ptr_q    <= first_q ? sh_q : ptr_q + 8'h01;
            first_q  <= 1'b0;
          end
          link_mon_pkg::I2C_WACK: begin
            st_q     <= link_mon_pkg::I2C_WDAT;
            bcnt_q   <= 4'h0;
            sda_oe_o <= 1'b0;
          end
          link_mon_pkg::I2C_RDAT: if (bcnt_q == 4'h8) begin
            st_q     <= link_mon_pkg::I2C_RACK;
            sda_oe_o <= 1'b0;
            ptr_q    <= ptr_q + 8'h01;
          end else begin
            sda_oe_o <= !sh_q[3'h7 - bcnt_q[2:0]];
          end
          default: st_q <= link_mon_pkg::I2C_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/lsm_props.sv ====
// port-level assertion checker for the link status monitor
`timescale 1ns/1ps
`default_nettype none
module lsm_props (
  input wire logic        core_clk_i,     // core clock
  input wire logic        rst_n_i,        // reset, active low
  input wire logic        scl_i,          // bus clock pin
  input wire logic        sda_o,          // data drive level
  input wire logic        sda_oe_o,       // data drive enable
  input wire logic        cmd_valid_o,    // command strobe
  input wire logic [15:0] cmd_data_o,     // command word
  input wire logic        fwd_prbs_o,     // self-test bit
  input wire logic        fwd_selftest_o, // self-test active
  input wire logic        volt_sel_o,     // sense pin select
  input wire logic        volt_en_o,      // sensor enable
  input wire logic [7:0]  sns_gain_o      // gain setting
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sda_low_a: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  ack_edge_a: assert property ($changed(sda_oe_o) |-> !$past(scl_i))
    else $error("data enable moved while bus clock high");
  cmd_pulse_a: assert property (cmd_valid_o |=> !cmd_valid_o [*8])
    else $error("command strobe too long or too close");
  cmd_hold_a: assert property ($changed(cmd_data_o) |-> $past(cmd_valid_o) or ##[0:1] cmd_valid_o)
    else $error("command word moved without a good frame");
  prbs_idle_a: assert property (!fwd_selftest_o |-> !fwd_prbs_o)
    else $error("stream bit set outside self-test");
  // either tap reading of the polynomial; one cycle of start-up lag tolerated
  prbs_seq_a: assert property (fwd_selftest_o [*8] ##1 fwd_selftest_o |->
    (fwd_prbs_o == ($past(fwd_prbs_o, 6) ^ $past(fwd_prbs_o, 7))) ||
    (fwd_prbs_o == ($past(fwd_prbs_o, 1) ^ $past(fwd_prbs_o, 7))))
    else $error("self-test stream not pseudo-random");
  st_src_a: assert property ($changed(fwd_selftest_o) |-> $past(cmd_valid_o) or ##[0:1] cmd_valid_o)
    else $error("self-test state moved without a good frame");
  cfg_wr_a: assert property ($changed({volt_sel_o, volt_en_o, sns_gain_o}) |-> !$past(scl_i))
    else $error("sensor setting moved outside a bus write");
endmodule
bind link_status_monitor lsm_props i_props (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .cmd_valid_o(cmd_valid_o), .cmd_data_o(cmd_data_o), .fwd_prbs_o(fwd_prbs_o),
  .fwd_selftest_o(fwd_selftest_o), .volt_sel_o(volt_sel_o), .volt_en_o(volt_en_o), .sns_gain_o(sns_gain_o));
`default_nettype wire

// ==== verification/deser_model.sv ====
// companion deserializer model: back-channel frame source
`timescale 1ns/1ps
`default_nettype none
module deser_model (
  output logic bc_clk_o,  // line clock, still between frames
  output logic bc_data_o, // serial data
  output logic bc_sync_o  // first-bit marker
);
  initial begin
    bc_clk_o = 1'b0;
    bc_data_o = 1'b0;
    bc_sync_o = 1'b0;
  end
  function automatic logic [7:0] crc8(input logic [21:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 21; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ (((c[7] ^ d[i]) == 1'b1) ? 8'h07 : 8'h00);
    return c;
  endfunction
  // payload: slots 3..0, self-test enable, remote lock, command
  task automatic send_frame(input logic [21:0] pl, input logic bad);
    logic [29:0] f;
    f = {pl, crc8(pl) ^ {7'h00, bad}};
    #7; // keep line edges off the core clock edge
    for (int i = 29; i >= 0; i--) begin
      bc_data_o = f[i];
      #160 bc_clk_o = 1'b1; // two line edges per bit at the fast rate
      #160 bc_clk_o = 1'b0;
      // sync must stand on the edge that takes the first bit
      bc_sync_o = (i == 29);
      #160 bc_clk_o = 1'b1;
      #160 bc_clk_o = 1'b0;
      bc_sync_o = 1'b0;
    end
    bc_data_o = ~bc_data_o; // released line shows no stale bit
  endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the link status monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        scl = 1'b1;
  logic        sda_m = 1'b1;
  logic        pll = 1'b1;
  logic [2:0]  vcode = 3'h3;
  logic [2:0]  tcode = 3'h3;
  logic [3:0]  gin = 4'h0;
  int          mismatches = 0;
  int          compares = 0;
  wire         bck, bcd, bcs, oe, cv, alm, vsel, ven, st;
  wire  [3:0]  gout, gen;
  wire  [7:0]  gain;
  wire  [15:0] cmd;
  wire         sda_w = sda_m & ~oe;
  always #20 clk = ~clk;
  deser_model i_deser (.bc_clk_o(bck), .bc_data_o(bcd), .bc_sync_o(bcs));
  link_status_monitor i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_w), .sda_o(),
    .sda_oe_o(oe), .bc_clk_i(bck), .bc_data_i(bcd), .bc_sync_i(bcs), .mode_strap_i(1'b1),
    .tx_pll_locked_i(pll), .volt_code_i(vcode), .temp_code_i(tcode), .gpio_i(gin), .gpio_o(gout),
    .gpio_oe_o(gen), .volt_sel_o(vsel), .volt_en_o(ven), .sns_gain_o(gain), .alarm_fwd_o(alm),
    .cmd_data_o(cmd), .cmd_valid_o(cv), .fwd_prbs_o(), .fwd_selftest_o(st));
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // data moves only while the bus clock is low, so no false start or stop
  task automatic bitx(input logic b, output logic r);
    scl <= 1'b0;
    w(2);
    sda_m <= b;
    w(3);
    scl <= 1'b1;
    w(5);
    r = sda_w;
  endtask
  task automatic cond(input logic a);
    scl <= 1'b0;
    w(3);
    sda_m <= a;
    w(3);
    scl <= 1'b1;
    w(5);
    sda_m <= ~a;
    w(5);
  endtask
  task automatic xb(input logic [7:0] d, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(1'b1, a);
    if (d != 8'hff) chk({15'h0, a}, 16'h0);
  endtask
  task automatic reg_wr(input logic [7:0] ad, input logic [7:0] d);
    logic [7:0] r;
    cond(1'b1);
    xb(8'h30, r);
    xb(ad, r);
    xb(d, r);
    cond(1'b0);
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] r;
    cond(1'b1);
    xb(8'h30, r);
    xb(ad, r);
    cond(1'b1);
    xb(8'h31, r);
    xb(8'hff, r);
    cond(1'b0);
    chk({8'h00, r & m}, {8'h00, e});
  endtask
  task automatic frm(input logic [21:0] p, input logic bad);
    i_deser.send_frame(p, bad);
    w(10);
  endtask
  task automatic t_status;
    rd_chk(8'h0e, 8'hff, 8'h0f);
    rd_chk(8'h1a, 8'hff, 8'h62);
    rd_chk(8'h59, 8'h01, 8'h01);
    rd_chk(8'h52, 8'h4e, 8'h04);
    pll <= 1'b0;
    rd_chk(8'h52, 8'h04, 8'h00);
    pll <= 1'b1;
    rd_chk(8'h20, 8'hff, 8'h00);
  endtask
  task automatic t_crc;
    frm({6'h01, 16'ha55a}, 1'b0);
    chk(cmd, 16'ha55a);
    rd_chk(8'h52, 8'h42, 8'h40);
    frm({6'h01, 16'h1234}, 1'b1);
    frm({6'h01, 16'h1234}, 1'b1);
    chk(cmd, 16'ha55a);
    rd_chk(8'h52, 8'h02, 8'h02);
    rd_chk(8'h55, 8'hff, 8'h02);
    rd_chk(8'h56, 8'hff, 8'h00);
    reg_wr(8'h49, 8'h08);
    rd_chk(8'h55, 8'hff, 8'h00);
    rd_chk(8'h49, 8'hff, 8'h00);
    frm({6'h01, 16'h1234}, 1'b1);
    rd_chk(8'h55, 8'hff, 8'h01);
  endtask
  task automatic t_selftest;
    frm({6'h03, 16'h0000}, 1'b0);
    chk({15'h0, st}, 16'h1);
    frm({6'h03, 16'h0000}, 1'b1);
    rd_chk(8'h52, 8'h08, 8'h08);
    rd_chk(8'h54, 8'hff, 8'h01);
    reg_wr(8'h49, 8'h20);
    rd_chk(8'h54, 8'hff, 8'h00);
    frm({6'h01, 16'h0000}, 1'b0);
    chk({15'h0, st}, 16'h0);
  endtask
  task automatic t_gpio;
    reg_wr(8'h0e, 8'hf0);
    chk({12'h0, gen}, 16'h000f);
    reg_wr(8'h0d, 8'h05);
    chk({12'h0, gout}, 16'h0005);
    gin <= 4'ha;
    rd_chk(8'h53, 8'h0f, 8'h0a);
    reg_wr(8'h0d, 8'h10);
    frm({6'h05, 16'h0000}, 1'b0);
    chk({12'h0, gout}, 16'h0001);
  endtask
  task automatic t_sensor;
    reg_wr(8'h17, 8'h03);
    chk({14'h0, ven, vsel}, 16'h0003);
    reg_wr(8'h18, 8'hb2);
    chk({8'h0, gain}, 16'h00b2);
    vcode <= 3'h1;
    tcode <= 3'h0;
    rd_chk(8'h57, 8'h0f, 8'h05);
    vcode <= 3'h7;
    tcode <= 3'h7;
    rd_chk(8'h57, 8'h0f, 8'h0a);
    reg_wr(8'h1d, 8'h01);
    chk({15'h0, alm}, 16'h0);
    reg_wr(8'h1e, 8'h01);
    chk({15'h0, alm}, 16'h1);
    vcode <= 3'h3;
    w(5);
    chk({15'h0, alm}, 16'h0);
  endtask
  task automatic report_and_stop;
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    w(4);
    rst_n <= 1'b1;
    w(8); // strap settles before the first bus start
    t_status;
    t_crc;
    t_selftest;
    t_gpio;
    t_sensor;
    report_and_stop;
  end
  // whole run needs about a seventh of this span
  initial begin
    #4_000_000;
    mismatches++;
    report_and_stop;
  end
endmodule
`default_nettype wire
